/* hdl/vcpu_iface_pkg.sv */
// constants and types for the virtual cpu interface control block
package vcpu_iface_pkg;
  // system-register encoding fields (coproc, opc1, crn, crm, opc2)
  localparam logic [3:0] ENC_COPROC     = 4'hf;
  localparam logic [2:0] ENC_OPC1       = 3'h4;
  localparam logic [3:0] ENC_CRN        = 4'hc;
  localparam logic [3:0] ENC_CRM        = 4'hb;
  localparam logic [2:0] ENC_OPC2_VMCR  = 3'h7;
  localparam logic [2:0] ENC_OPC2_VTR   = 3'h1;
  // virtual_machine_control field positions
  localparam int PMASK_HI = 31;
  localparam int PMASK_LO = 24;
  localparam int BP0_HI   = 23;
  localparam int BP0_LO   = 21;
  localparam int BP1_HI   = 20;
  localparam int BP1_LO   = 18;
  localparam int EOIM_BIT = 9;
  localparam int CBPR_BIT = 4;
  localparam int FIQ_BIT  = 3;
  localparam int ACK_BIT  = 2;
  localparam int ENG1_BIT = 1;
  localparam int ENG0_BIT = 0;
  // virtual_interface_type field positions
  localparam int PRI_HI   = 31;
  localparam int PRI_LO   = 29;
  localparam int PRE_HI   = 28;
  localparam int PRE_LO   = 26;
  localparam int IDW_HI   = 25;
  localparam int IDW_LO   = 23;
  localparam int SYS_ERROR_IRQ_SUPPORT_BIT = 22;
  localparam int A3V_BIT  = 21;
  localparam int NV4_BIT  = 20;
  localparam int TDS_BIT  = 19;
  localparam int LRC_HI   = 4;
  localparam int LRC_LO   = 0;
  // implementation figures (reported minus one where the field says so)
  localparam logic [2:0] PRI_BITS_M1   = 3'h4;
  localparam logic [2:0] PRE_BITS_M1   = 3'h4;
  localparam logic [2:0] IDW_16        = 3'h0;
  localparam logic [2:0] IDW_24        = 3'h1;
  localparam logic [4:0] LIST_CNT_M1   = 5'h03;
  localparam logic [2:0] BP_SAT        = 3'h7;
  localparam logic [9:0] ID_SPURIOUS_G1 = 10'h3fe;
  localparam logic [7:0] PRIO_RESET    = 8'h00;
  localparam logic [2:0] BP_RESET      = 3'h0;
  localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
  // mask of writable control bits
  localparam logic [31:0] VMCR_WMASK   = 32'hfffc_021f;
  typedef enum logic [1:0] {ACC_NONE, ACC_VMCR, ACC_VTR} acc_sel_t;
endpackage

/* hdl/bp_group_mask.sv */
// binary point to group-priority mask for an eight-bit priority
`timescale 1ns/1ps
module bp_group_mask
  import vcpu_iface_pkg::*;
(
  input  wire logic [2:0] bp,
  input  wire logic [7:0] prio,
  output logic      [7:0] group_prio
);
  // bits below bp+1 are subpriority and are cleared
  always_comb begin
    group_prio = prio & (8'hff << ({1'b0, bp} + 4'h1));
  end
endmodule

/* hdl/vmcr_field_reg.sv */
// one field of the control register with reset and write enable
`timescale 1ns/1ps
module vmcr_field_reg #(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         mclk,
  input  wire logic         rstn,
  input  wire logic         we,
  input  wire logic [W-1:0] wdata,
  output logic      [W-1:0] q
);
  logic [W-1:0] q_d;
  always_comb begin
    q_d = we ? wdata : q;
  end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      q <= RST;
    end else begin
      q <= q_d;
    end
  end
endmodule

/* hdl/virtual_cpu_iface_ctrl.sv */
// virtual cpu interface control/type registers and signalling logic
// Contract
// - signal only priority higher than mask
// - group 0 binary point sets preemption
// - common bit clear: group 1 point used
// - split off: eoi drops and deactivates
// - split on: deactivate only via register
// - common set: group1 point reads g0+1
// - common clear: group1 point independent
// - fiq route picks irq or fiq
// - sysreg forced: fiq route reads one
// - ack control selects 1022 or id
// - sysreg forced: ack control reads zero
// - bits 1,0 enable groups 1,0
// - no hyp level: control reads zero
// - type reports priority bits minus one
// - type reports preemption bits minus one
// - identifier width encoding 16/24 bits
// - bit 22 system error support
// - bit 21 top affinity valid
// - bit 20 no direct injection, one
// - no hyp level: type zero except 20
// - bit 19 deactivate trap support
// - bits 4:0 list count minus one
// - group 1 always irq, gated enable
`timescale 1ns/1ps
module virtual_cpu_iface_ctrl
  import vcpu_iface_pkg::*;
#(
  parameter bit HYP_PRESENT    = 1'b1,
  parameter bit SRE_FORCED     = 1'b0,
  parameter bit ID24           = 1'b0,
  parameter bit SEI_SUPPORT    = 1'b0,
  parameter bit AFF3_SUPPORT   = 1'b0,
  parameter bit TDIR_SUPPORT   = 1'b0
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  // system-register access port
  input  wire logic        sysreg_valid,
  input  wire logic        sysreg_write,
  input  wire logic        sysreg_el3,
  input  wire logic [3:0]  sysreg_coproc,
  input  wire logic [2:0]  sysreg_opc1,
  input  wire logic [3:0]  sysreg_crn,
  input  wire logic [3:0]  sysreg_crm,
  input  wire logic [2:0]  sysreg_opc2,
  input  wire logic [31:0] sysreg_wdata,
  output logic      [31:0] sysreg_rdata,
  output logic             sysreg_ack,
  // virtual interface accesses from the guest side
  input  wire logic        bp1_wr,
  input  wire logic [2:0]  bp1_wdata,
  output logic      [2:0]  bp1_rdata,
  output logic      [2:0]  bp0_rdata,
  input  wire logic        eoi_wr,
  input  wire logic        dir_wr,
  output logic             prio_drop,
  output logic             deactivate,
  // highest pending interrupt from the list logic
  input  wire logic        hp_valid,
  input  wire logic        hp_group1,
  input  wire logic [7:0]  hp_prio,
  input  wire logic [9:0]  hp_id,
  input  wire logic [7:0]  running_prio,
  output logic      [9:0]  ack_id,
  output logic             virq,
  output logic             vfiq
);
  logic [7:0]  pmask_q;
  logic [2:0]  bp0_q;
  logic [2:0]  bp1_q;
  logic        eoim_q;
  logic        cbpr_q;
  logic        fiq_raw_q;
  logic        ack_raw_q;
  logic        eng1_q;
  logic        eng0_q;
  logic        fiq_en;
  logic        ack_en;
  logic        vmcr_we;
  logic        bp1_we;
  logic [2:0]  bp1_wval;
  logic [2:0]  bp1_eff;
  logic [3:0]  bp0_inc;
  logic [31:0] vmcr_word;
  logic [31:0] vtr_word;
  logic [31:0] rdata_d;
  logic        ack_d;
  logic [9:0]  ack_id_d;
  logic        virq_d;
  logic        vfiq_d;
  logic        drop_d;
  logic        deact_d;
  logic [7:0]  hp_group;
  logic [7:0]  run_group;
  logic        preempt;
  acc_sel_t    sel;

  // decode the coprocessor encoding of the two registers
  always_comb begin
    sel = ACC_NONE;
    if (sysreg_valid && sysreg_coproc == ENC_COPROC && sysreg_opc1 == ENC_OPC1 &&
        sysreg_crn == ENC_CRN && sysreg_crm == ENC_CRM) begin
      if (sysreg_opc2 == ENC_OPC2_VMCR) begin
        sel = ACC_VMCR;
      end else if (sysreg_opc2 == ENC_OPC2_VTR) begin
        sel = ACC_VTR;
      end
    end
  end

  // without the hyp level the register is write-ignored as well as zero
  assign vmcr_we = (sel == ACC_VMCR) && sysreg_write && HYP_PRESENT;

  // guest writes to the group 1 point are dropped while common mode holds
  assign bp1_we   = vmcr_we || (bp1_wr && !cbpr_q);
  assign bp1_wval = vmcr_we ? sysreg_wdata[BP1_HI:BP1_LO] : bp1_wdata;

  // live state fields; reserved bits have no storage at all
  vmcr_field_reg #(.W(8), .RST(PRIO_RESET)) u_pmask (
    .mclk(mclk), .rstn(rstn), .we(vmcr_we), .wdata(sysreg_wdata[PMASK_HI:PMASK_LO]), .q(pmask_q));
  vmcr_field_reg #(.W(3), .RST(BP_RESET)) u_bp0 (
    .mclk(mclk), .rstn(rstn), .we(vmcr_we), .wdata(sysreg_wdata[BP0_HI:BP0_LO]), .q(bp0_q));
  vmcr_field_reg #(.W(3), .RST(BP_RESET)) u_bp1 (
    .mclk(mclk), .rstn(rstn), .we(bp1_we), .wdata(bp1_wval), .q(bp1_q));
  vmcr_field_reg #(.W(6)) u_bits (
    .mclk(mclk), .rstn(rstn), .we(vmcr_we),
    .wdata({sysreg_wdata[EOIM_BIT], sysreg_wdata[CBPR_BIT], sysreg_wdata[FIQ_BIT],
            sysreg_wdata[ACK_BIT], sysreg_wdata[ENG1_BIT], sysreg_wdata[ENG0_BIT]}),
    .q({eoim_q, cbpr_q, fiq_raw_q, ack_raw_q, eng1_q, eng0_q}));

  // hardwired bits when system register access is always on
  assign fiq_en = SRE_FORCED ? 1'b1 : fiq_raw_q;
  assign ack_en = SRE_FORCED ? 1'b0 : ack_raw_q;

  // group 1 point: g0+1 saturating in common mode, else its own field
  assign bp0_inc = {1'b0, bp0_q} + 4'h1;
  always_comb begin
    if (cbpr_q) begin
      bp1_eff = (bp0_q == BP_SAT) ? BP_SAT : bp0_inc[2:0];
    end else begin
      bp1_eff = bp1_q;
    end
  end
  assign bp0_rdata = bp0_q;
  assign bp1_rdata = bp1_eff;

  // assemble the control word; unlisted bits stay zero
  always_comb begin
    vmcr_word = WORD_ZERO;
    vmcr_word[PMASK_HI:PMASK_LO] = pmask_q;
    vmcr_word[BP0_HI:BP0_LO]     = bp0_q;
    vmcr_word[BP1_HI:BP1_LO]     = bp1_q;
    vmcr_word[EOIM_BIT]          = eoim_q;
    vmcr_word[CBPR_BIT]          = cbpr_q;
    vmcr_word[FIQ_BIT]           = fiq_en;
    vmcr_word[ACK_BIT]           = ack_en;
    vmcr_word[ENG1_BIT]          = eng1_q;
    vmcr_word[ENG0_BIT]          = eng0_q;
    if (!HYP_PRESENT) begin
      vmcr_word = WORD_ZERO;
    end
  end

  // assemble the read-only type word
  always_comb begin
    vtr_word = WORD_ZERO;
    vtr_word[PRI_HI:PRI_LO] = PRI_BITS_M1;
    vtr_word[PRE_HI:PRE_LO] = PRE_BITS_M1;
    vtr_word[IDW_HI:IDW_LO] = ID24 ? IDW_24 : IDW_16;
    vtr_word[SYS_ERROR_IRQ_SUPPORT_BIT]      = SEI_SUPPORT;
    vtr_word[A3V_BIT]       = AFF3_SUPPORT;
    vtr_word[NV4_BIT]       = 1'b1;
    vtr_word[TDS_BIT]       = TDIR_SUPPORT;
    vtr_word[LRC_HI:LRC_LO] = LIST_CNT_M1;
    if (!HYP_PRESENT) begin
      vtr_word = WORD_ZERO;
      vtr_word[NV4_BIT] = 1'b1;
    end
  end

  // read data and completion, one cycle after the request
  always_comb begin
    ack_d   = sel != ACC_NONE;
    rdata_d = WORD_ZERO;
    case (sel)
      ACC_VMCR: rdata_d = sysreg_write ? WORD_ZERO : vmcr_word;
      ACC_VTR:  rdata_d = sysreg_write ? WORD_ZERO : vtr_word;
      ACC_NONE: rdata_d = WORD_ZERO;
      default:  rdata_d = WORD_ZERO;
    endcase
  end

  // group priority compares for preemption
  bp_group_mask u_hp_grp (
    .bp((hp_group1 ? bp1_eff : bp0_q)),
    .prio(hp_prio),
    .group_prio(hp_group));
  bp_group_mask u_run_grp (
    .bp((hp_group1 ? bp1_eff : bp0_q)),
    .prio(running_prio),
    .group_prio(run_group));
  assign preempt = hp_group < run_group;

  // signalling: lower value means higher priority
  always_comb begin
    virq_d = 1'b0;
    vfiq_d = 1'b0;
    if (hp_valid && (hp_prio < pmask_q) && preempt) begin
      if (hp_group1) begin
        virq_d = eng1_q;
      end else if (eng0_q) begin
        vfiq_d = fiq_en;
        virq_d = !fiq_en;
      end
    end
  end

  // acknowledge id: group 1 hidden as 1022 unless ack control is set
  always_comb begin
    ack_id_d = hp_id;
    if (hp_group1 && !ack_en) begin
      ack_id_d = ID_SPURIOUS_G1;
    end
  end

  // eoi and deactivate split; dir with split off is unpredictable, ignored here
  always_comb begin
    drop_d  = eoi_wr;
    deact_d = eoim_q ? dir_wr : eoi_wr;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sysreg_rdata <= WORD_ZERO;
      sysreg_ack   <= 1'b0;
      ack_id       <= '0;
      virq         <= 1'b0;
      vfiq         <= 1'b0;
      prio_drop    <= 1'b0;
      deactivate   <= 1'b0;
    end else begin
      sysreg_rdata <= rdata_d;
      sysreg_ack   <= ack_d;
      ack_id       <= ack_id_d;
      virq         <= virq_d;
      vfiq         <= vfiq_d;
      prio_drop    <= drop_d;
      deactivate   <= deact_d;
    end
  end
endmodule

/* verif/virtual_cpu_iface_ctrl_asserts.sv */
// checker for the virtual cpu interface control block
`timescale 1ns/1ps
module virtual_cpu_iface_ctrl_asserts
  import vcpu_iface_pkg::*;
#(
  parameter bit HYP_PRESENT = 1'b1,
  parameter bit SRE_FORCED  = 1'b0
) (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        sysreg_valid,
  input wire logic        sysreg_write,
  input wire logic [3:0]  sysreg_coproc,
  input wire logic [2:0]  sysreg_opc1,
  input wire logic [3:0]  sysreg_crn,
  input wire logic [3:0]  sysreg_crm,
  input wire logic [2:0]  sysreg_opc2,
  input wire logic [31:0] sysreg_wdata,
  input wire logic [31:0] sysreg_rdata,
  input wire logic        sysreg_ack,
  input wire logic [2:0]  bp1_rdata,
  input wire logic [2:0]  bp0_rdata,
  input wire logic        bp1_wr,
  input wire logic [2:0]  bp1_wdata,
  input wire logic        eoi_wr,
  input wire logic        dir_wr,
  input wire logic        prio_drop,
  input wire logic        deactivate,
  input wire logic        hp_valid,
  input wire logic        hp_group1,
  input wire logic [7:0]  hp_prio,
  input wire logic [9:0]  ack_id,
  input wire logic        virq,
  input wire logic        vfiq
);
  localparam logic [31:0] VTR_EXP = {PRI_BITS_M1, PRE_BITS_M1, IDW_16, 4'h2, 14'h0, LIST_CNT_M1};
  logic [31:0] sh_q;
  localparam logic [31:0] VTR_NOHYP = 32'h0000_0001 << NV4_BIT;
  logic [31:0] sh_d;
  logic [31:0] sh_v;
  logic        hit;
  logic        wr_c;
  logic        rd_c;
  // decode; a missed access must never be acked
  assign hit = sysreg_valid && sysreg_coproc == ENC_COPROC && sysreg_opc1 == ENC_OPC1
    && sysreg_crn == ENC_CRN && sysreg_crm == ENC_CRM;
  assign wr_c = hit && sysreg_write && sysreg_opc2 == ENC_OPC2_VMCR && HYP_PRESENT;
  assign rd_c = hit && !sysreg_write && sysreg_opc2 == ENC_OPC2_VMCR;
  // shadow control word, reference for field checks
  // guest group 1 writes land only while common mode is off; a control write wins
  always_comb begin
    sh_d = sh_q;
    if (bp1_wr && !sh_q[CBPR_BIT]) begin
      sh_d[BP1_HI:BP1_LO] = bp1_wdata;
    end
    if (wr_c) begin
      sh_d = sysreg_wdata & VMCR_WMASK;
    end
  end
  always_ff @(posedge mclk) sh_q <= rstn ? sh_d : WORD_ZERO;
  // view with the hardwired routing bits applied
  always_comb begin
    sh_v = sh_q;
    sh_v[FIQ_BIT] = SRE_FORCED || sh_q[FIQ_BIT];
    sh_v[ACK_BIT] = !SRE_FORCED && sh_q[ACK_BIT];
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  AST_ACK: assert property (hit && (sysreg_opc2 == ENC_OPC2_VMCR || sysreg_opc2 == ENC_OPC2_VTR)
    |=> sysreg_ack) else $error("access not acked");
  AST_NOACK: assert property (!hit |=> !sysreg_ack) else $error("ack without access");
  AST_TYPE: assert property (
    hit && !sysreg_write && sysreg_opc2 == ENC_OPC2_VTR
    |=> sysreg_rdata == (HYP_PRESENT ? VTR_EXP : VTR_NOHYP)) else $error("type word");
  AST_CTRL_RD: assert property (
    rd_c |=> sysreg_rdata == (HYP_PRESENT ? $past(sh_v) : WORD_ZERO)) else $error("control readback");
  AST_BP1_SAT: assert property (
    sh_q[CBPR_BIT] |-> bp1_rdata == ((sh_q[BP0_HI:BP0_LO] == BP_SAT) ? BP_SAT
    : sh_q[BP0_HI:BP0_LO] + 3'h1)) else $error("bp1 view");
  AST_BP0: assert property (
    bp0_rdata == sh_q[BP0_HI:BP0_LO]) else $error("bp0 view");
  AST_BP1_OWN: assert property (
    !sh_q[CBPR_BIT] |-> bp1_rdata == sh_q[BP1_HI:BP1_LO]) else $error("bp1 own field");
  AST_EOI_FULL: assert property (
    eoi_wr && !sh_q[EOIM_BIT] |=> prio_drop && deactivate) else $error("eoi full");
  AST_EOI_SPLIT: assert property (
    eoi_wr && !dir_wr && sh_q[EOIM_BIT] |=> prio_drop && !deactivate) else $error("eoi split");
  AST_DIR: assert property (
    dir_wr && sh_q[EOIM_BIT] |=> deactivate) else $error("dir");
  AST_FIQ: assert property (
    vfiq |-> $past(hp_valid && !hp_group1 && sh_v[FIQ_BIT] && sh_q[ENG0_BIT])) else $error("vfiq cause");
  AST_G1: assert property (
    virq && $past(hp_group1) |-> $past(sh_q[ENG1_BIT])) else $error("group 1 gate");
  AST_MASK: assert property (
    virq || vfiq |-> $past(hp_prio < sh_q[PMASK_HI:PMASK_LO])) else $error("mask");
  AST_ACKID: assert property (
    hp_valid && hp_group1 && !sh_v[ACK_BIT] |=> ack_id == ID_SPURIOUS_G1) else $error("ack id");
  cover property (wr_c);
  cover property (vfiq);
  cover property (eoi_wr && sh_q[EOIM_BIT]);
endmodule

/* verif/virtual_cpu_iface_ctrl_test.sv */
// self-checking testbench for the virtual cpu interface control block
`timescale 1ns/1ps
module virtual_cpu_iface_ctrl_test
  import vcpu_iface_pkg::*;
;
  localparam logic [31:0] VTR_EXP = {PRI_BITS_M1, PRE_BITS_M1, IDW_16, 4'h2, 14'h0, LIST_CNT_M1};
  logic        mclk, rstn, sysreg_valid, sysreg_write, bp1_wr, eoi_wr, dir_wr;
  logic        hp_valid, hp_group1, sysreg_ack, prio_drop, deactivate, virq, vfiq;
  logic [2:0]  sysreg_opc2, bp1_wdata, bp1_rdata, bp0_rdata;
  logic [31:0] sysreg_wdata, sysreg_rdata;
  logic [7:0]  hp_prio, running_prio;
  logic [9:0]  hp_id, ack_id, ack_id_sre;
  logic [31:0] rd_sre, rd_nohyp;
  logic [3:0]  sysreg_crm;
  logic        vfiq_sre;
  int          n_fail, compares;
  virtual_cpu_iface_ctrl uut (.*, .sysreg_el3(1'b0), .sysreg_coproc(ENC_COPROC),
    .sysreg_opc1(ENC_OPC1), .sysreg_crn(ENC_CRN));
  // same stimulus, routing bits hardwired
  virtual_cpu_iface_ctrl #(.SRE_FORCED(1'b1)) uut_sre (.*, .sysreg_el3(1'b0), .sysreg_coproc(ENC_COPROC),
    .sysreg_opc1(ENC_OPC1), .sysreg_crn(ENC_CRN), .sysreg_rdata(rd_sre), .sysreg_ack(), .bp1_rdata(),
    .bp0_rdata(), .prio_drop(), .deactivate(), .ack_id(ack_id_sre), .virq(), .vfiq(vfiq_sre));
  // same stimulus, no hyp level: only the monitor view exists
  virtual_cpu_iface_ctrl #(.HYP_PRESENT(1'b0)) uut_nohyp (.*, .sysreg_el3(1'b1), .sysreg_coproc(ENC_COPROC),
    .sysreg_opc1(ENC_OPC1), .sysreg_crn(ENC_CRN), .sysreg_rdata(rd_nohyp), .sysreg_ack(), .bp1_rdata(),
    .bp0_rdata(), .prio_drop(), .deactivate(), .ack_id(), .virq(), .vfiq());
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one register access; ack stands from the taking edge, one cycle after the request is driven
  task automatic acc(input logic w, input logic [2:0] op, input logic [31:0] wd, input logic ek,
                     input logic [31:0] ed);
    @(posedge mclk);
    sysreg_valid <= 1'b1;
    sysreg_write <= w;
    sysreg_opc2 <= op;
    sysreg_wdata <= wd;
    @(posedge mclk);
    sysreg_valid <= 1'b0;
    #1;
    chk(sysreg_ack, ek);
    chk(sysreg_rdata, ed);
  endtask
  // present a pending interrupt, look at the registered outputs
  task automatic sig(input logic g1, input logic [7:0] pr, input logic [1:0] ev, input logic sp);
    @(posedge mclk);
    hp_group1 <= g1;
    hp_prio <= pr;
    hp_id <= {2'h0, pr};
    @(posedge mclk);
    #1;
    chk({virq, vfiq}, ev);
    chk(ack_id, sp ? ID_SPURIOUS_G1 : {2'h0, pr});
  endtask
  task automatic pend(input logic e, input logic d, input logic [1:0] ex);
    @(posedge mclk);
    eoi_wr <= e;
    dir_wr <= d;
    @(posedge mclk);
    eoi_wr <= 1'b0;
    dir_wr <= 1'b0;
    #1;
    chk({prio_drop, deactivate}, ex);
  endtask
  task automatic gbp(input logic [2:0] v, input logic [2:0] ex);
    @(posedge mclk);
    bp1_wr <= 1'b1;
    bp1_wdata <= v;
    @(posedge mclk);
    bp1_wr <= 1'b0;
    #1;
    chk(bp1_rdata, ex);
  endtask
  task automatic summarize;
    if (n_fail == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #100us;
    n_fail++;
    summarize();
  end
  initial begin
    {rstn, sysreg_valid, sysreg_write, bp1_wr, eoi_wr, dir_wr, hp_group1} = '0;
    {sysreg_opc2, bp1_wdata, sysreg_wdata, hp_prio, hp_id} = '0;
    hp_valid = 1'b1;
    sysreg_crm = ENC_CRM;
    running_prio = 8'hff;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    acc(0, ENC_OPC2_VTR, 0, 1, VTR_EXP);
    chk(rd_nohyp, 32'h0010_0000);
    acc(1, ENC_OPC2_VTR, '1, 1, 0);
    acc(0, ENC_OPC2_VTR, 0, 1, VTR_EXP);
    acc(0, 3'h2, 0, 0, 0);
    @(posedge mclk) sysreg_crm <= 4'ha;
    acc(0, ENC_OPC2_VTR, 0, 0, 0);
    @(posedge mclk) sysreg_crm <= ENC_CRM;
    acc(0, ENC_OPC2_VMCR, 0, 1, 0);
    acc(1, ENC_OPC2_VMCR, '1, 1, 0);
    acc(0, ENC_OPC2_VMCR, 0, 1, VMCR_WMASK);
    chk(rd_sre, 32'hfffc_021b);
    chk(rd_nohyp, 32'h0000_0000);
    acc(1, ENC_OPC2_VMCR, 32'h80c0_0013, 1, 0);
    chk(bp1_rdata, 3'h7);
    gbp(3'h1, 3'h7);
    acc(0, ENC_OPC2_VMCR, 0, 1, 32'h80c0_0013);
    acc(1, ENC_OPC2_VMCR, 32'h80e0_0013, 1, 0);
    chk(bp1_rdata, 3'h7);
    acc(1, ENC_OPC2_VMCR, 32'h80c8_0003, 1, 0);
    chk({bp1_rdata, bp0_rdata}, 6'h16);
    gbp(3'h5, 3'h5);
    acc(0, ENC_OPC2_VMCR, 0, 1, 32'h80d4_0003);
    chk(rd_sre, 32'h80d4_000b);
    sig(0, 8'h7f, 2'b10, 0);
    chk(vfiq_sre, 1'b1);
    sig(0, 8'h80, 2'b00, 0);
    sig(1, 8'h10, 2'b10, 1);
    @(posedge mclk) running_prio <= 8'h00;
    sig(1, 8'h10, 2'b00, 1);
    @(posedge mclk) running_prio <= 8'h7f;
    sig(1, 8'h10, 2'b10, 1);
    sig(0, 8'h10, 2'b00, 0);
    @(posedge mclk) running_prio <= 8'hff;
    acc(1, ENC_OPC2_VMCR, 32'h80c8_000b, 1, 0);
    sig(0, 8'h10, 2'b01, 0);
    acc(1, ENC_OPC2_VMCR, 32'h80c8_000d, 1, 0);
    sig(1, 8'h10, 2'b00, 0);
    chk(ack_id_sre, ID_SPURIOUS_G1);
    acc(1, ENC_OPC2_VMCR, 32'h80c8_000e, 1, 0);
    sig(0, 8'h10, 2'b00, 0);
    @(posedge mclk) hp_valid <= 1'b0;
    sig(1, 8'h10, 2'b00, 0);
    @(posedge mclk) hp_valid <= 1'b1;
    pend(1, 0, 2'b11);
    acc(1, ENC_OPC2_VMCR, 32'h80c8_0203, 1, 0);
    pend(1, 0, 2'b10);
    pend(0, 1, 2'b01);
    summarize();
  end
endmodule
bind virtual_cpu_iface_ctrl virtual_cpu_iface_ctrl_asserts #(
  .HYP_PRESENT (HYP_PRESENT),
  .SRE_FORCED  (SRE_FORCED)
) chk_u (
  .mclk         (mclk),
  .rstn         (rstn),
  .sysreg_valid (sysreg_valid),
  .sysreg_write (sysreg_write),
  .sysreg_coproc(sysreg_coproc),
  .sysreg_opc1  (sysreg_opc1),
  .sysreg_crn   (sysreg_crn),
  .sysreg_crm   (sysreg_crm),
  .sysreg_opc2  (sysreg_opc2),
  .sysreg_wdata (sysreg_wdata),
  .sysreg_rdata (sysreg_rdata),
  .sysreg_ack   (sysreg_ack),
  .bp1_rdata    (bp1_rdata),
  .bp0_rdata    (bp0_rdata),
  .bp1_wr       (bp1_wr),
  .bp1_wdata    (bp1_wdata),
  .eoi_wr       (eoi_wr),
  .dir_wr       (dir_wr),
  .prio_drop    (prio_drop),
  .deactivate   (deactivate),
  .hp_valid     (hp_valid),
  .hp_group1    (hp_group1),
  .hp_prio      (hp_prio),
  .ack_id       (ack_id),
  .virq         (virq),
  .vfiq         (vfiq)
);
